/* File: core/pcl_pkg.sv */
package pcl_pkg;
   // Register indices; the byte address on the bus is four times the index.
   localparam logic [4:0] IDX_CARRIER = 5'h07;
   localparam logic [4:0] IDX_COEF_FIRST = 5'h0b;
   localparam logic [4:0] IDX_COEF_LAST = 5'h1b;
   localparam logic [4:0] IDX_POLARITY = 5'h1b;
   localparam logic [4:0] IDX_TABLE_CTRL = 5'h1d;
   localparam logic [4:0] IDX_STATUS = 5'h1e;
   // Geometry of the stored words and of the coefficient table.
   localparam int WORD_W = 24;
   localparam int COEF_W = 12;
   localparam int COEF_WORDS = 17;
   localparam int COEF_LAST_ENTRY = 32;
   localparam int LANES = 3;
   // Field positions.
   localparam int CARRIER_LSB = 0;
   localparam int CARRIER_W = 3;
   localparam int PRE_INV_BIT = 21;
   localparam int POST_INV_BIT = 22;
   localparam int EVEN_LSB = 0;
   localparam int ODD_LSB = 12;
   localparam int TABLE_VALID_BIT = 0;
   localparam int STAT_RES_LSB = 0;
   localparam int STAT_CODE_LSB = 4;
   localparam int STAT_VALID_BIT = 8;
   // Reset values.
   localparam logic [2:0] CARRIER_RST = 3'h0;
   localparam logic PRE_INV_RST = 1'b0;
   localparam logic POST_INV_RST = 1'b0;
   localparam logic TABLE_VALID_RST = 1'b0;
   // Timing: slowest carrier period and the clock period, in nanoseconds.
   localparam longint CARRIER_SLOW_NS = 64'd8000000;
   localparam longint CLOCK_NS = 64'd4;
   localparam int CARRIER_SLOW_CYC = int'(CARRIER_SLOW_NS / CLOCK_NS);
   // Read answer takes this many wait cycles.
   localparam logic [1:0] READ_WAIT = 2'h2;
endpackage : pcl_pkg

/* File: core/pcl_coef_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module pcl_coef_mem #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 17,
   parameter int AW = 5,
   parameter int LANES = 3
) (
   // Clock.
   input wire logic clock_i,
   // Write port with one enable per byte lane.
   input wire logic [LANES-1:0] wr_lane_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   // Registered read port for the bus.
   input wire logic [AW-1:0] a_addr_i,
   output logic [WIDTH-1:0] a_data_o,
   // Registered read port for the coefficient lookup.
   input wire logic [AW-1:0] b_addr_i,
   output logic [WIDTH-1:0] b_data_o
);
   // Storage array; contents are not reset, like non-volatile words.
   logic [WIDTH-1:0] mem_q [DEPTH];

   // Each byte lane is written on its own enable.
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      always_ff @(posedge clock_i) begin
         if (wr_lane_i[l] && (int'(wr_addr_i) < DEPTH)) begin
            mem_q[wr_addr_i][l*8 +: 8] <= wr_data_i[l*8 +: 8];
         end
      end
   end

   // Both read ports deliver their word one edge after the address.
   always_ff @(posedge clock_i) begin
      a_data_o <= (int'(a_addr_i) < DEPTH) ? mem_q[a_addr_i] : '0;
      b_data_o <= (int'(b_addr_i) < DEPTH) ? mem_q[b_addr_i] : '0;
   end
endmodule : pcl_coef_mem
`default_nettype wire

/* File: core/pcl_top.sv */
// Summary of operation
// - Word 7 bits 2:0 select carrier.
// - Codes map 0.125 to 4 kHz, rest 0.125.
// - Word 0x1B bit 21 inverts before linearizer.
// - Pre-inversion only while table valid.
// - Word 0x1B bit 22 inverts after linearizer.
// - Post-inversion works without a table.
// - Even entries in bits 11:0, 0x0B-0x1B.
// - Odd entries in bits 23:12, 0x0B-0x1A.
// - Coefficients ignored unless table valid.
`timescale 1ns/100ps
`default_nettype none
module pcl_top #(
   parameter int SLOW_PERIOD_CYC = pcl_pkg::CARRIER_SLOW_CYC,
   parameter int SAMPLE_W = 12
) (
   // Clock and synchronous active-low reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Avalon-MM slave, byte addressed.
   input wire logic [6:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Sample entering the linearizer path.
   input wire logic [SAMPLE_W-1:0] sample_i,
   input wire logic sample_valid_i,
   output logic [SAMPLE_W-1:0] lin_in_o,
   output logic lin_in_valid_o,
   // Result returned by the linearizer.
   input wire logic [SAMPLE_W-1:0] lin_result_i,
   input wire logic lin_result_valid_i,
   output logic [SAMPLE_W-1:0] level_o,
   output logic level_valid_o,
   // Coefficient lookup for the linearizer.
   input wire logic [5:0] coeff_idx_i,
   output logic [pcl_pkg::COEF_W-1:0] coeff_o,
   output logic coeff_used_o,
   output logic lin_enable_o,
   // Carrier and pulse output.
   output logic [3:0] resolution_o,
   output logic carrier_start_o,
   output logic pwm_o
);
   // Carrier period in cycles for a selector code.
   function automatic logic [31:0] period_of(input logic [2:0] code);
      logic [31:0] base;
      base = 32'(SLOW_PERIOD_CYC);
      unique case (code)
         3'h1: period_of = base >> 1;
         3'h2: period_of = base >> 2;
         3'h3: period_of = base >> 3;
         3'h4: period_of = base >> 4;
         3'h5: period_of = base >> 5;
         default: period_of = base;
      endcase
   endfunction : period_of

   // Largest output resolution for a selector code.
   function automatic logic [3:0] res_of(input logic [2:0] code);
      unique case (code)
         3'h3: res_of = 4'hb;
         3'h4: res_of = 4'ha;
         3'h5: res_of = 4'h9;
         default: res_of = 4'hc;
      endcase
   endfunction : res_of

   // Mirror of a value about mid-scale.
   function automatic logic [SAMPLE_W-1:0] mirror(input logic [SAMPLE_W-1:0] v);
      mirror = ~v;
   endfunction : mirror

   // Configuration state.
   logic [2:0] carrier_q; // Carrier selector.
   logic pre_inv_q; // Invert ahead of the linearizer.
   logic post_inv_q; // Invert after the linearizer.
   logic table_valid_q; // Coefficient table is complete.
   logic [pcl_pkg::WORD_W-1:0] carrier_word_q; // Full carrier word for read-back.

   // Bus decode.
   logic [4:0] idx; // Register index.
   logic in_table; // Index falls in the coefficient words.
   logic [4:0] mem_idx; // Index relative to the first coefficient word.
   logic [2:0] lanes; // Byte enables of the stored lanes.
   logic [1:0] rd_cnt_q; // Read wait counter.
   logic [pcl_pkg::WORD_W-1:0] mem_a_data; // Bus read word from the table.
   logic [pcl_pkg::WORD_W-1:0] mem_b_data; // Lookup word from the table.

   assign idx = avs_address_i[6:2];
   assign in_table = (idx >= pcl_pkg::IDX_COEF_FIRST) && (idx <= pcl_pkg::IDX_COEF_LAST);
   assign mem_idx = idx - pcl_pkg::IDX_COEF_FIRST;
   assign lanes = avs_byteenable_i[2:0];

   // Reads wait two cycles; writes complete at once.
   assign avs_waitrequest_o = avs_read_i && (rd_cnt_q != pcl_pkg::READ_WAIT);

   // Read wait counter restarts after each answered read.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rd_cnt_q <= 2'h0;
      end else if (avs_read_i && (rd_cnt_q != pcl_pkg::READ_WAIT)) begin
         rd_cnt_q <= rd_cnt_q + 2'h1;
      end else begin
         rd_cnt_q <= 2'h0;
      end
   end

   // Read data are loaded one edge after the table word arrives.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i && (rd_cnt_q == 2'h1)) begin
         if (in_table) begin
            avs_readdata_o <= {8'h0, mem_a_data};
         end else if (idx == pcl_pkg::IDX_CARRIER) begin
            avs_readdata_o <= {8'h0, carrier_word_q};
         end else if (idx == pcl_pkg::IDX_TABLE_CTRL) begin
            avs_readdata_o <= {31'h0, table_valid_q};
         end else if (idx == pcl_pkg::IDX_STATUS) begin
            avs_readdata_o <= 32'h0;
            avs_readdata_o[pcl_pkg::STAT_RES_LSB +: 4] <= res_of(carrier_q);
            avs_readdata_o[pcl_pkg::STAT_CODE_LSB +: 3] <= carrier_q;
            avs_readdata_o[pcl_pkg::STAT_VALID_BIT] <= table_valid_q;
         end else begin
            avs_readdata_o <= 32'h0; // Unmapped reads return zero.
         end
      end
   end

   // Carrier word: the selector steers the pulse generator.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         carrier_word_q <= '0;
         carrier_q <= pcl_pkg::CARRIER_RST;
      end else if (avs_write_i && (idx == pcl_pkg::IDX_CARRIER)) begin
         for (int l = 0; l < pcl_pkg::LANES; l++) begin
            if (lanes[l]) begin
               carrier_word_q[l*8 +: 8] <= avs_writedata_i[l*8 +: 8];
            end
         end
         if (lanes[0]) begin
            carrier_q <= avs_writedata_i[pcl_pkg::CARRIER_LSB +: pcl_pkg::CARRIER_W];
         end
      end
   end

   // Polarity bits are shadowed from the last table word.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pre_inv_q <= pcl_pkg::PRE_INV_RST;
         post_inv_q <= pcl_pkg::POST_INV_RST;
      end else if (avs_write_i && (idx == pcl_pkg::IDX_POLARITY) && lanes[2]) begin
         pre_inv_q <= avs_writedata_i[pcl_pkg::PRE_INV_BIT];
         post_inv_q <= avs_writedata_i[pcl_pkg::POST_INV_BIT];
      end
   end

   // Table valid flag, written by software once the table is loaded.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         table_valid_q <= pcl_pkg::TABLE_VALID_RST;
      end else if (avs_write_i && (idx == pcl_pkg::IDX_TABLE_CTRL) && lanes[0]) begin
         table_valid_q <= avs_writedata_i[pcl_pkg::TABLE_VALID_BIT];
      end
   end

   // Coefficient lookup: entry n lives in word n/2, upper half when odd.
   logic [4:0] lk_word; // Word holding the requested entry.
   logic lk_ok; // Requested entry exists.
   logic [1:0] lk_odd_q; // Odd flag pipelined with the read.
   logic [1:0] lk_ok_q; // Existence pipelined with the read.
   assign lk_word = coeff_idx_i[5:1];
   assign lk_ok = (int'(coeff_idx_i) <= pcl_pkg::COEF_LAST_ENTRY);

   pcl_coef_mem #(
      .WIDTH(pcl_pkg::WORD_W),
      .DEPTH(pcl_pkg::COEF_WORDS),
      .AW(5),
      .LANES(pcl_pkg::LANES)
   ) u_mem (
      .clock_i(clock_i),
      .wr_lane_i((avs_write_i && in_table) ? lanes : 3'h0),
      .wr_addr_i(mem_idx),
      .wr_data_i(avs_writedata_i[pcl_pkg::WORD_W-1:0]),
      .a_addr_i(mem_idx),
      .a_data_o(mem_a_data),
      .b_addr_i(lk_word),
      .b_data_o(mem_b_data)
   );

   // Coefficient appears two edges after its index; zero while the table is invalid.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         lk_odd_q <= 2'h0;
         lk_ok_q <= 2'h0;
         coeff_o <= '0;
         coeff_used_o <= 1'b0;
      end else begin
         lk_odd_q <= {lk_odd_q[0], coeff_idx_i[0]};
         lk_ok_q <= {lk_ok_q[0], lk_ok};
         coeff_used_o <= table_valid_q && lk_ok_q[0];
         if (!table_valid_q || !lk_ok_q[0]) begin
            coeff_o <= '0;
         end else if (lk_odd_q[0]) begin
            coeff_o <= mem_b_data[pcl_pkg::ODD_LSB +: pcl_pkg::COEF_W];
         end else begin
            coeff_o <= mem_b_data[pcl_pkg::EVEN_LSB +: pcl_pkg::COEF_W];
         end
      end
   end
   assign lin_enable_o = table_valid_q;

   // Sample ahead of the linearizer, inverted only with a valid table.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         lin_in_o <= '0;
         lin_in_valid_o <= 1'b0;
      end else begin
         lin_in_valid_o <= sample_valid_i;
         if (sample_valid_i) begin
            lin_in_o <= (pre_inv_q && table_valid_q) ? mirror(sample_i) : sample_i;
         end
      end
   end

   // Level after the linearizer; inversion is independent of the table.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         level_o <= '0;
         level_valid_o <= 1'b0;
      end else begin
         level_valid_o <= lin_result_valid_i;
         if (lin_result_valid_i) begin
            level_o <= post_inv_q ? mirror(lin_result_i) : lin_result_i;
         end
      end
   end

   // Pulse generator: period from the selector, duty from the level at the allowed resolution.
   logic [31:0] period; // Current carrier period.
   logic [3:0] res; // Current resolution.
   logic [31:0] phase_q; // Position inside the period.
   logic [31:0] duty_q; // High time latched at each period start.
   logic [31:0] duty_d; // High time for the present level.
   assign period = period_of(carrier_q);
   assign res = res_of(carrier_q);
   assign duty_d = 32'((32'(level_o) >> (4'hc - res)) * (period >> res));
   assign resolution_o = res;

   // Phase counter wraps at the period, restarting when the selector shortens it.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         phase_q <= 32'h0;
         duty_q <= 32'h0;
         carrier_start_o <= 1'b0;
      end else begin
         carrier_start_o <= (phase_q + 32'h1 >= period);
         if (phase_q + 32'h1 >= period) begin
            phase_q <= 32'h0;
            duty_q <= duty_d;
         end else begin
            phase_q <= phase_q + 32'h1;
         end
      end
   end

   // Output is high for the first part of each period.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pwm_o <= 1'b0;
      end else begin
         pwm_o <= (phase_q < duty_q);
      end
   end

   // Checks.
   a_carrier_sel_ff: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (avs_write_i && idx == pcl_pkg::IDX_CARRIER && lanes[0]) |=> (carrier_q == $past(avs_writedata_i[2:0])))
      else $error("carrier selector not taken from write");
   a_carrier_fall_back: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (carrier_q[2:1] == 2'h3) |-> (period == 32'(SLOW_PERIOD_CYC) && res == 4'hc))
      else $error("reserved carrier code not at slowest rate");
   a_res_by_code: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (carrier_q == 3'h5) |-> (res == 4'h9 && period == 32'(SLOW_PERIOD_CYC) >> 5))
      else $error("fastest carrier has wrong resolution");
   a_pre_inv_on: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (sample_valid_i && pre_inv_q && table_valid_q) |=> (lin_in_o == ~$past(sample_i)))
      else $error("pre inversion missing");
   a_pre_inv_gated: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (sample_valid_i && !table_valid_q) |=> (lin_in_o == $past(sample_i)))
      else $error("pre inversion applied without valid table");
   a_post_inv_out: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (lin_result_valid_i && post_inv_q) |=> (level_o == ~$past(lin_result_i)) && level_valid_o)
      else $error("post inversion missing");
   a_post_no_table: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (lin_result_valid_i && post_inv_q && !table_valid_q) |=> (level_o == ~$past(lin_result_i)))
      else $error("post inversion missing without a valid table");
   a_post_pass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (lin_result_valid_i && !post_inv_q) |=> (level_o == $past(lin_result_i)))
      else $error("level changed without inversion");
   a_coeff_gated: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !table_valid_q |=> (coeff_o == '0 && !coeff_used_o))
      else $error("coefficient used without valid table");
   a_coeff_odd_half: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (table_valid_q && lk_ok_q[0] && lk_odd_q[0]) |=> (coeff_o == $past(mem_b_data[23:12])))
      else $error("odd entry from wrong half");
   a_coeff_even_half: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (table_valid_q && lk_ok_q[0] && !lk_odd_q[0]) |=> (coeff_o == $past(mem_b_data[11:0])))
      else $error("even entry from wrong half");
   // Bus timing: a read is answered after exactly two wait cycles.
   a_read_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (avs_read_i && rd_cnt_q == 2'h0) |-> avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("read answer timing wrong");
   c_fast_carrier: cover property (@(posedge clock_i) disable iff (!rst_n_i) carrier_q == 3'h5 && carrier_start_o);
   c_pre_inverted: cover property (@(posedge clock_i) disable iff (!rst_n_i) lin_in_valid_o && pre_inv_q && table_valid_q);
   c_coeff_read: cover property (@(posedge clock_i) disable iff (!rst_n_i) coeff_used_o && lk_odd_q[1]);
endmodule : pcl_top
`default_nettype wire

/* File: tb/pwm_carrier_and_lin_polarity_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// One comparison: counts it, and reports and counts a mismatch at once.
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
   $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module pwm_carrier_and_lin_polarity_tb;
   // Slowest carrier of 4096 cycles gives one cycle per level step at 12 bits, so pulse widths are measurable.
   localparam int SLOW = 4096;
   // Design inputs, all given a value at time zero.
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [6:0] avs_address_i = 7'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [3:0] avs_byteenable_i = 4'h0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [11:0] sample_i = 12'h000;
   logic sample_valid_i = 1'b0;
   logic [11:0] lin_result_i = 12'h000;
   logic lin_result_valid_i = 1'b0;
   logic [5:0] coeff_idx_i = 6'h00;
   // Design outputs.
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [11:0] lin_in_o, level_o, coeff_o;
   logic lin_in_valid_o, level_valid_o, coeff_used_o, lin_enable_o;
   logic [3:0] resolution_o;
   logic carrier_start_o, pwm_o;
   // Result counters.
   int err_total = 0;
   int comparisons = 0;

   // The clock toggles every half period of 2 ns.
   always #2 clock_i = ~clock_i;

   pcl_top #(.SLOW_PERIOD_CYC(SLOW), .SAMPLE_W(12)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .sample_i(sample_i), .sample_valid_i(sample_valid_i), .lin_in_o(lin_in_o),
      .lin_in_valid_o(lin_in_valid_o), .lin_result_i(lin_result_i),
      .lin_result_valid_i(lin_result_valid_i), .level_o(level_o), .level_valid_o(level_valid_o),
      .coeff_idx_i(coeff_idx_i), .coeff_o(coeff_o), .coeff_used_o(coeff_used_o),
      .lin_enable_o(lin_enable_o), .resolution_o(resolution_o),
      .carrier_start_o(carrier_start_o), .pwm_o(pwm_o));

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // One Avalon access, held until waitrequest is sampled low; one idle edge follows.
   task automatic bus(input logic wr, input logic [6:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_byteenable_i <= be;
      avs_writedata_i <= d;
      do begin
         @(posedge clock_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clock_i);
      if (n >= 50) begin
         err_total++;
         $display("[ERR] waitrequest expected 0 seen stuck");
         test_done();
      end
   endtask : bus

   // Waits for the next carrier start pulse and returns the cycles waited.
   task automatic next_start(output int n);
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (carrier_start_o !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         err_total++;
         $display("[ERR] carrier_start_o expected pulse seen none");
         test_done();
      end
   endtask : next_start

   // Expected resolution for a selector code.
   function automatic logic [3:0] res_of(input int c);
      return (c == 3) ? 4'hb : (c == 4) ? 4'ha : (c == 5) ? 4'h9 : 4'hc;
   endfunction : res_of

   // Coefficient value for an entry; rises with the entry number.
   function automatic logic [11:0] cv(input int e);
      return 12'(e * 16 + 1);
   endfunction : cv

   // Main sequence of tests.
   initial begin
      logic [31:0] q;
      int n;
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      // Reset values of the carrier word, the table flag and the status word.
      bus(1'b0, 7'h1c, 4'hf, 32'h0, q);
      `CHK("carrier word", 32'h0, q)
      bus(1'b0, 7'h78, 4'hf, 32'h0, q);
      `CHK("status", 32'h00c, q)
      `CHK("lin_enable_o", 1'b0, lin_enable_o)
      // Unmapped index: write ignored, read gives zero.
      bus(1'b1, 7'h04, 4'hf, 32'h00ffffff, q);
      bus(1'b0, 7'h04, 4'hf, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      $display("test reset done");
      // Every selector code: readback, resolution and carrier period.
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 7'h1c, 4'h1, 32'(c), q);
         bus(1'b0, 7'h1c, 4'hf, 32'h0, q);
         `CHK("selector", 32'(c), q)
         `CHK("resolution_o", res_of(c), resolution_o)
         bus(1'b0, 7'h78, 4'hf, 32'h0, q);
         `CHK("status", {23'h0, 1'b0, 1'b0, 3'(c), res_of(c)}, q)
         next_start(n);
         next_start(n);
         next_start(n);
         `CHK("period", (c < 6) ? (SLOW >> c) : SLOW, n)
      end
      $display("test carrier done");
      // Post inversion works while the table is not valid; mirror about mid-scale.
      bus(1'b1, 7'h6c, 4'h4, 32'h00400000, q);
      lin_result_i <= 12'h123;
      lin_result_valid_i <= 1'b1;
      @(posedge clock_i);
      lin_result_valid_i <= 1'b0;
      @(posedge clock_i);
      `CHK("level_valid_o", 1'b1, level_valid_o)
      `CHK("level_o", 12'hedc, level_o)
      bus(1'b1, 7'h6c, 4'h4, 32'h00200000, q);
      lin_result_valid_i <= 1'b1;
      @(posedge clock_i);
      lin_result_valid_i <= 1'b0;
      @(posedge clock_i);
      `CHK("level_o", 12'h123, level_o)
      // Pre inversion is ignored while the table is not valid.
      sample_i <= 12'h0f0;
      sample_valid_i <= 1'b1;
      @(posedge clock_i);
      sample_valid_i <= 1'b0;
      @(posedge clock_i);
      `CHK("lin_in_valid_o", 1'b1, lin_in_valid_o)
      `CHK("lin_in_o", 12'h0f0, lin_in_o)
      $display("test polarity done");
      // Pulse width at the slowest carrier: level 0x123 at full resolution is high for that many cycles.
      next_start(n);
      n = 0;
      repeat (400) begin
         @(posedge clock_i);
         if (pwm_o === 1'b1) begin
            n++;
         end
      end
      `CHK("pwm_o high cycles", 32'h123 * (SLOW >> 12), n)
      $display("test pulse done");
      // Table load: even entries low half, odd entries high half; values rise.
      for (int k = 0; k < 17; k++) begin
         bus(1'b1, 7'(8'h2c + 4 * k), (k < 16) ? 4'hf : 4'h3,
             {8'h00, (k < 16) ? cv(2 * k + 1) : 12'h000, cv(2 * k)}, q);
      end
      for (int k = 0; k < 16; k++) begin
         bus(1'b0, 7'(8'h2c + 4 * k), 4'hf, 32'h0, q);
         `CHK("table word", {8'h00, cv(2 * k + 1), cv(2 * k)}, q)
      end
      // Coefficients are ignored until the table is marked valid.
      coeff_idx_i <= 6'd5;
      repeat (3) @(posedge clock_i);
      `CHK("coeff_o", 12'h000, coeff_o)
      `CHK("coeff_used_o", 1'b0, coeff_used_o)
      bus(1'b1, 7'h74, 4'h1, 32'h1, q);
      `CHK("lin_enable_o", 1'b1, lin_enable_o)
      for (int e = 0; e < 34; e++) begin
         coeff_idx_i <= 6'(e);
         repeat (3) @(posedge clock_i);
         `CHK("coeff_o", (e < 33) ? cv(e) : 12'h000, coeff_o)
         `CHK("coeff_used_o", (e < 33) ? 1'b1 : 1'b0, coeff_used_o)
      end
      // With the table valid the pre inversion takes effect.
      sample_valid_i <= 1'b1;
      @(posedge clock_i);
      sample_valid_i <= 1'b0;
      @(posedge clock_i);
      `CHK("lin_in_o", 12'hf0f, lin_in_o)
      bus(1'b0, 7'h6c, 4'hf, 32'h0, q);
      `CHK("polarity bits", 2'h1, q[22:21])
      $display("test table done");
      test_done();
   end
endmodule : pwm_carrier_and_lin_polarity_tb
`default_nettype wire
